/* fcp_axi_master.sv */
// Purpose: AXI4-Lite master standing in for the core or the debug port
// Assumes: One write and one read at most under way
// Notes: Released valid, address and data lines show the inverse of their last value; wstrb keeps its value
`timescale 1ns/1ps
module fcp_axi_master
(
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

  // Write; bready stands from the offer until the answer is sampled
  // Core and debug port share this one path, so both are modelled alike
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      #1;
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta)
      begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (tw)
      begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (tb)
        bready <= 1'b0;
    end
  endtask : wr

  // Read; rready stands from the offer until the answer is sampled
  task automatic rd(input logic [7:0] a);
    logic tg, td;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    td = 1'b0;
    while (!td)
    begin
      #1;
      tg = arvalid & arready;
      td = rvalid;
      @(posedge aclk);
      if (tg)
      begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
      if (td)
        rready <= 1'b0;
    end
  endtask : rd
endmodule : fcp_axi_master

/* fcp_permit.sv */
// Purpose: Permission check of one command against the protection state
// Assumes: Purely combinational, evaluated when a command starts
// Notes: Section decided from page address against boot end and log start
`timescale 1ns/1ps
module fcp_permit
  import fcp_pkg::*;
(
  input wire logic [7:0] cmd,
  input wire fcp_minfo_s minfo,
  input wire fcp_allow_s allow,
  input wire logic [31:0] page_addr,
  input wire logic [31:0] sec_bounds,
  output logic permit
);

  logic no_lock;
  logic in_boot;
  logic in_log;

  // Section and lock decode; master identity plays no part
  always_comb
  begin
    no_lock = !minfo.perm_lock && !minfo.key_lock;
    in_boot = page_addr[15:0] < sec_bounds[15:0];
    in_log = page_addr[15:0] >= sec_bounds[31:16];
  end

  // Permission table per command code
  always_comb
  begin
    case (cmd)
      FCP_C_ERASE_MAIN, FCP_C_ERASE_BP, FCP_C_ERASE_PROG: permit = 1'b1;
      FCP_C_PAGE_ERASE: permit = in_log || no_lock;
      FCP_C_ERASE_KEY: permit = no_lock || allow.key_ok;
      FCP_C_UNLOCK: permit = minfo.key_lock && !minfo.perm_lock;
      FCP_C_ENV_LOAD: permit = 1'b1;
      FCP_C_WRITE: permit = in_log || no_lock ||
        (in_boot ? allow.boot_ok : allow.prog_ok);
      FCP_C_SET_KEY, FCP_C_SET_BND: permit = no_lock;
      FCP_C_PERM_LOCK, FCP_C_KEY_LOCK: permit = no_lock;
      default: permit = 1'b0; // Unknown codes never run
    endcase
  end

endmodule : fcp_permit

/* fcp_pkg.sv */
// Purpose: Shared constants and types of the flash command permission unit
// Assumes: 32-bit AXI4-Lite register access, 20 MHz aclk
// Notes: Memory info layout: [31:30] fail count, [29] perm lock, [28] key lock
package fcp_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] FCP_OFS_CMD = 8'h00; // command code, write
  localparam logic [7:0] FCP_OFS_EXE = 8'h04; // execute command
  localparam logic [7:0] FCP_OFS_STAT = 8'h08; // status
  localparam logic [7:0] FCP_OFS_MINFO = 8'h0c; // memory info, read only
  localparam logic [7:0] FCP_OFS_ADDR = 8'h10; // flash page address
  localparam logic [7:0] FCP_OFS_BND = 8'h14; // boundary value for 0d
  localparam logic [7:0] FCP_OFS_KEY = 8'h18; // unlock key / new key
  localparam logic [7:0] FCP_OFS_CLR = 8'h1c; // clear allow flags
  localparam logic [7:0] FCP_OFS_ENV = 8'h20; // environment value for 09
  localparam logic [7:0] FCP_OFS_SEC = 8'h24; // section bounds (boot end, log start)

  // ****************************************************
  // Field positions and reset values
  // ****************************************************
  localparam int FCP_STAT_DONE = 0;
  localparam int FCP_STAT_BUSY = 4;
  localparam int FCP_STAT_KEY = 5;
  localparam int FCP_STAT_BOOT = 6;
  localparam int FCP_STAT_PROG = 7;
  localparam int FCP_STAT_REJ = 8;
  localparam int FCP_MI_PERM = 29;
  localparam int FCP_MI_KLOCK = 28;
  localparam logic [27:0] FCP_BND_ONES = 28'hfffffff;
  localparam logic [31:0] FCP_MINFO_RST = 32'h0fffffff;
  localparam logic [31:0] FCP_KEY_RST = 32'h00000000;
  localparam logic [1:0] FCP_FAIL_MAX = 2'h3;

  // ****************************************************
  // Command codes
  // ****************************************************
  localparam logic [7:0] FCP_C_ERASE_MAIN = 8'h00;
  localparam logic [7:0] FCP_C_ERASE_BP = 8'h02;
  localparam logic [7:0] FCP_C_ERASE_PROG = 8'h03;
  localparam logic [7:0] FCP_C_PAGE_ERASE = 8'h04;
  localparam logic [7:0] FCP_C_ERASE_KEY = 8'h06;
  localparam logic [7:0] FCP_C_UNLOCK = 8'h08;
  localparam logic [7:0] FCP_C_ENV_LOAD = 8'h09;
  localparam logic [7:0] FCP_C_WRITE = 8'h0a;
  localparam logic [7:0] FCP_C_SET_KEY = 8'h0c;
  localparam logic [7:0] FCP_C_SET_BND = 8'h0d;
  localparam logic [7:0] FCP_C_PERM_LOCK = 8'h0e;
  localparam logic [7:0] FCP_C_KEY_LOCK = 8'h0f;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int FCP_CLK_MHZ = 20;
  localparam int FCP_OP_US = 2; // stand-in duration of one array operation
  localparam int FCP_OP_CYC_I = (FCP_OP_US * FCP_CLK_MHZ < 1) ? 1 : FCP_OP_US * FCP_CLK_MHZ;
  localparam logic [7:0] FCP_OP_CYC = FCP_OP_CYC_I[7:0];

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [2:0]
  {
    FCP_IDLE = 3'b001,
    FCP_RUN = 3'b010,
    FCP_END = 3'b100
  } fcp_state_e;

  typedef struct packed
  {
    logic [1:0] fail_cnt;
    logic perm_lock;
    logic key_lock;
    logic [27:0] bounds;
  } fcp_minfo_s;

  typedef struct packed
  {
    logic key_ok;
    logic boot_ok;
    logic prog_ok;
  } fcp_allow_s;

endpackage : fcp_pkg

/* fcp_unit.sv */
// Purpose: Command front end with protection bookkeeping and AXI4-Lite slave
// Assumes: Core and debug port share the one register bus
// Notes: Array operations are a fixed-length wait; outcome is bookkeeping only
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

module fcp_unit
  import fcp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic command_busy_flag
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [31:0] fcp_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : fcp_merge

  // ****************************************************
  // State
  // ****************************************************
  fcp_state_e state, next_state;
  logic [7:0] cmd_reg, next_cmd_reg;
  logic [31:0] addr_reg, next_addr_reg;
  logic [31:0] bnd_reg, next_bnd_reg;
  logic [31:0] key_in, next_key_in;
  logic [31:0] env_reg, next_env_reg;
  logic [31:0] sec_reg, next_sec_reg;
  logic [31:0] stored_key, next_stored_key;
  fcp_minfo_s memory_info_reg, next_memory_info_reg;
  fcp_allow_s allow, next_allow;
  logic command_done_flag, next_command_done_flag;
  logic reject_flag, next_reject_flag;
  logic [7:0] op_cnt, next_op_cnt;
  logic [7:0] run_cmd, next_run_cmd;
  logic aw_held, next_aw_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic permit;
  logic wr_go;
  logic rd_go;
  logic start;
  logic [31:0] stat_word;

  fcp_permit u_permit
  (
    .cmd(cmd_reg),
    .minfo(memory_info_reg),
    .allow(allow),
    .page_addr(addr_reg),
    .sec_bounds(sec_reg),
    .permit(permit)
  );

  // ****************************************************
  // Bus handshake
  // ****************************************************
  // Both bus masters land here, so origin never enters the
  always_comb
  begin
    s_axi_awready = !aw_held;
    s_axi_wready = !w_held;
    s_axi_bvalid = bvalid;
    s_axi_bresp = bresp;
    s_axi_arready = !rvalid;
    s_axi_rvalid = rvalid;
    s_axi_rdata = rdata;
    s_axi_rresp = rresp;
    command_busy_flag = (state != FCP_IDLE);
    // Writes are postponed, not refused, while a command runs
    wr_go = aw_held && w_held && !bvalid && (state == FCP_IDLE);
    rd_go = s_axi_arvalid && !rvalid;
    start = wr_go && (aw_addr == FCP_OFS_EXE) && w_strb[0] && w_data[0];
    stat_word = 32'h00000000;
    stat_word[FCP_STAT_DONE] = command_done_flag;
    stat_word[FCP_STAT_BUSY] = command_busy_flag;
    stat_word[FCP_STAT_KEY] = allow.key_ok;
    stat_word[FCP_STAT_BOOT] = allow.boot_ok;
    stat_word[FCP_STAT_PROG] = allow.prog_ok;
    stat_word[FCP_STAT_REJ] = reject_flag;
  end

  // Register writes, reads and bus channel holding
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_cmd_reg = cmd_reg;
    next_addr_reg = addr_reg;
    next_bnd_reg = bnd_reg;
    next_key_in = key_in;
    next_env_reg = env_reg;
    next_sec_reg = sec_reg;
    if (s_axi_awvalid && !aw_held)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_held)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (wr_go)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = 2'b00;
      case (aw_addr)
        FCP_OFS_CMD: next_cmd_reg = w_strb[0] ? w_data[7:0] : cmd_reg; // Code sits in lane 0
        FCP_OFS_ADDR: next_addr_reg = fcp_merge(addr_reg, w_data, w_strb);
        FCP_OFS_BND: next_bnd_reg = fcp_merge(bnd_reg, w_data, w_strb);
        FCP_OFS_KEY: next_key_in = fcp_merge(key_in, w_data, w_strb);
        FCP_OFS_ENV: next_env_reg = fcp_merge(env_reg, w_data, w_strb);
        FCP_OFS_SEC: next_sec_reg = fcp_merge(sec_reg, w_data, w_strb);
        FCP_OFS_EXE, FCP_OFS_CLR, FCP_OFS_STAT, FCP_OFS_MINFO: next_bresp = 2'b00;
        default: next_bresp = 2'b10; // Unmapped: slave error
      endcase
    end
    if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    // Reads are answered even while a command runs
    if (rd_go && s_axi_arvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp = 2'b00;
      case ({s_axi_araddr[7:2], 2'b00})
        FCP_OFS_CMD: next_rdata = {24'h000000, cmd_reg};
        FCP_OFS_EXE: next_rdata = 32'h00000000;
        FCP_OFS_STAT: next_rdata = stat_word;
        FCP_OFS_MINFO: next_rdata = memory_info_reg;
        FCP_OFS_ADDR: next_rdata = addr_reg;
        FCP_OFS_BND: next_rdata = bnd_reg;
        FCP_OFS_KEY, FCP_OFS_CLR: next_rdata = 32'h00000000; // Key never readable
        FCP_OFS_ENV: next_rdata = env_reg;
        FCP_OFS_SEC: next_rdata = sec_reg;
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = 2'b10;
        end
      endcase
    end
  end

  // ****************************************************
  // Command sequencer and protection state
  // ****************************************************
  // Outcome is applied only at the end of the command, never on refusal
  always_comb
  begin
    next_state = state;
    next_op_cnt = op_cnt;
    next_run_cmd = run_cmd;
    next_memory_info_reg = memory_info_reg;
    next_allow = allow;
    next_stored_key = stored_key;
    next_command_done_flag = command_done_flag;
    next_reject_flag = reject_flag;
    // Done flag clears on a status read; a same-cycle set below wins
    if (rd_go && ({s_axi_araddr[7:2], 2'b00} == FCP_OFS_STAT))
    begin
      next_command_done_flag = 1'b0;
      next_reject_flag = 1'b0;
    end
    if (wr_go && (aw_addr == FCP_OFS_CLR) && w_strb[0] && w_data[0])
    begin
      next_allow = '0;
    end
    case (state)
      FCP_IDLE:
      begin
        if (start)
        begin
          if (permit)
          begin
            next_state = FCP_RUN; // Busy rises here
            next_run_cmd = cmd_reg;
            next_op_cnt = FCP_OP_CYC;
          end
          else
          begin
            next_reject_flag = 1'b1; // No state touched
            next_command_done_flag = 1'b1;
          end
        end
      end
      FCP_RUN:
      begin
        if (op_cnt <= 8'h01)
        begin
          next_state = FCP_END;
        end
        else
        begin
          next_op_cnt = op_cnt - 8'h01;
        end
      end
      FCP_END:
      begin
        next_state = FCP_IDLE;
        next_command_done_flag = 1'b1;
        case (run_cmd)
          FCP_C_ERASE_MAIN, FCP_C_ERASE_BP:
          begin
            next_allow = '{key_ok: 1'b1, boot_ok: 1'b1, prog_ok: 1'b1};
          end
          FCP_C_ERASE_PROG:
          begin
            next_allow.key_ok = 1'b1;
            next_allow.prog_ok = 1'b1;
          end
          FCP_C_ERASE_KEY:
          begin
            next_memory_info_reg.fail_cnt = 2'b00;
            next_memory_info_reg.perm_lock = 1'b0;
            next_memory_info_reg.key_lock = 1'b0;
            next_memory_info_reg.bounds = FCP_BND_ONES;
            next_stored_key = FCP_KEY_RST;
          end
          FCP_C_UNLOCK:
          begin
            if (key_in == stored_key)
            begin
              next_allow.key_ok = 1'b1;
              next_memory_info_reg.key_lock = 1'b0;
            end
            else
            begin
              next_memory_info_reg.fail_cnt = memory_info_reg.fail_cnt + 2'b01;
              if (memory_info_reg.fail_cnt == FCP_FAIL_MAX - 2'b01)
              begin
                next_memory_info_reg.perm_lock = 1'b1;
              end
            end
          end
          FCP_C_ENV_LOAD: next_memory_info_reg = env_reg;
          FCP_C_SET_KEY: next_stored_key = key_in;
          FCP_C_SET_BND: next_memory_info_reg.bounds = bnd_reg[27:0];
          FCP_C_PERM_LOCK: next_memory_info_reg.perm_lock = 1'b1;
          FCP_C_KEY_LOCK: next_memory_info_reg.key_lock = 1'b1;
          default: next_run_cmd = run_cmd; // Page erase and write alter no protection
        endcase
      end
      default: next_state = FCP_IDLE;
    endcase
  end

  // Register all state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= FCP_IDLE;
      op_cnt <= 8'h00;
      run_cmd <= 8'h00;
      memory_info_reg <= FCP_MINFO_RST;
      allow <= '0;
      stored_key <= FCP_KEY_RST;
      command_done_flag <= 1'b0;
      reject_flag <= 1'b0;
      cmd_reg <= 8'h00;
      addr_reg <= 32'h00000000;
      bnd_reg <= 32'h00000000;
      key_in <= 32'h00000000;
      env_reg <= FCP_MINFO_RST;
      sec_reg <= 32'h00000000;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'b00;
    end
    else
    begin
      state <= next_state;
      op_cnt <= next_op_cnt;
      run_cmd <= next_run_cmd;
      memory_info_reg <= next_memory_info_reg;
      allow <= next_allow;
      stored_key <= next_stored_key;
      command_done_flag <= next_command_done_flag;
      reject_flag <= next_reject_flag;
      cmd_reg <= next_cmd_reg;
      addr_reg <= next_addr_reg;
      bnd_reg <= next_bnd_reg;
      key_in <= next_key_in;
      env_reg <= next_env_reg;
      sec_reg <= next_sec_reg;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

endmodule : fcp_unit

/* fcp_unit_props.sv */
// Purpose: Port checks of the flash command permission unit
// Assumes: One clock domain, synchronous active-low reset
// Notes: Busy length counts the end state and allows one cycle of slack beyond it
`timescale 1ns/1ps
module fcp_unit_chk
  import fcp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic command_busy_flag
);
  logic [7:0] busy_cnt;
  logic [7:0] next_busy_cnt;

  // Busy cycle count; saturates so a stuck busy cannot wrap into the window
  always_comb
  begin
    next_busy_cnt = 8'h00;
    if (command_busy_flag)
      next_busy_cnt = (busy_cnt == 8'hff) ? busy_cnt : busy_cnt + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      busy_cnt <= 8'h00;
    else
      busy_cnt <= next_busy_cnt;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_busy_len;
    $fell(command_busy_flag) |-> busy_cnt >= FCP_OP_CYC + 8'h01 && busy_cnt <= FCP_OP_CYC + 8'h02;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_start;
    $rose(command_busy_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy without write");
  property p_b_no_busy;
    $rose(s_axi_bvalid) |-> !$past(command_busy_flag);
  endproperty
  a_b_no_busy: assert property (p_b_no_busy) else $error("write done while busy");
  property p_rd_busy;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read not answered");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_aw_held;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_held: assert property (p_aw_held) else $error("address not held");
  property p_reset;
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !command_busy_flag;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : fcp_unit_chk

bind fcp_unit fcp_unit_chk u_chk
(
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .command_busy_flag(command_busy_flag)
);

/* tb_top.sv */
// Purpose: Self-checking bench of the flash command permission unit
// Assumes: Master model drives the register bus, 50 ns clock
// Notes: Expected reads are queued by the driver, compared by a monitor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top
  import fcp_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, k, b, e, fl;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busy;
  logic [1:0] bresp, rresp;
  logic [41:0] expq[$];
  logic [41:0] ex;
  logic [1:0] bq[$];
  logic [1:0] bx;
  int checks = 0;
  int n_fail = 0;

  always #25 aclk = ~aclk;

  fcp_unit DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .command_busy_flag(busy));

  fcp_axi_master u_mst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

  // Monitor: oldest note against each read answer
  always @(posedge aclk)
  begin
    if (aresetn && rvalid && rready)
    begin
      ex = expq.pop_front();
      `CHK("rdata", ex[31:0], rdata)
      `CHK("rresp", ex[33:32], rresp)
    end
    if (aresetn && bvalid && bready)
    begin
      bx = bq.pop_front();
      `CHK("bresp", bx, bresp)
    end
  end

  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    expq.push_back({a, (a > FCP_OFS_SEC) ? 2'b10 : 2'b00, v});
    u_mst.rd(a);
  endtask : rd

  // Unmapped write answers with a slave error, mapped ones with okay
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bq.push_back((a > FCP_OFS_SEC) ? 2'b10 : 2'b00);
    u_mst.wr(a, d);
  endtask : wr

  // Execute last; busy status read mid-run, then final status and memory info
  task automatic cmd(input logic [7:0] c, input logic [31:0] st, input logic [31:0] mi);
    wr(FCP_OFS_CMD, {24'h0, c});
    wr(FCP_OFS_EXE, 32'h1);
    if (!st[FCP_STAT_REJ])
    begin
      rd(FCP_OFS_STAT, fl | 32'h10);
      wr(FCP_OFS_CMD, {24'h0, c}); // Held off until the command ends
      `CHK("busy", 1'b0, busy)
    end
    repeat (200) if (busy) @(posedge aclk);
    rd(FCP_OFS_STAT, st);
    rd(FCP_OFS_MINFO, mi);
    fl = st & 32'he0;
  endtask : cmd

  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    results();
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    void'($urandom(45));
    k = $urandom() | 32'h1;
    b = $urandom();
    e = $urandom();
    fl = 32'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(FCP_OFS_MINFO, FCP_MINFO_RST);
    rd(FCP_OFS_STAT, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'h0);
    wr(FCP_OFS_SEC, 32'h0100_0010);
    cmd(FCP_C_KEY_LOCK, 32'h001, 32'h1fffffff);
    cmd(FCP_C_SET_KEY, 32'h101, 32'h1fffffff);
    wr(FCP_OFS_KEY, k);
    for (int i = 1; i <= 3; i++)
      cmd(FCP_C_UNLOCK, 32'h001, {i[1:0], (i == 3), 1'b1, FCP_BND_ONES});
    cmd(FCP_C_UNLOCK, 32'h101, 32'hffffffff);
    wr(FCP_OFS_ADDR, 32'h20);
    cmd(FCP_C_WRITE, 32'h101, 32'hffffffff);
    cmd(FCP_C_PAGE_ERASE, 32'h101, 32'hffffffff);
    wr(FCP_OFS_ADDR, 32'h200);
    cmd(FCP_C_PAGE_ERASE, 32'h001, 32'hffffffff);
    cmd(FCP_C_ERASE_PROG, 32'h0a1, 32'hffffffff);
    wr(FCP_OFS_ADDR, 32'h20);
    cmd(FCP_C_WRITE, 32'h0a1, 32'hffffffff);
    wr(FCP_OFS_ADDR, 32'h5);
    cmd(FCP_C_WRITE, 32'h1a1, 32'hffffffff);
    cmd(FCP_C_ERASE_KEY, 32'h0a1, FCP_MINFO_RST);
    cmd(FCP_C_ERASE_MAIN, 32'h0e1, FCP_MINFO_RST);
    wr(FCP_OFS_CLR, 32'h1);
    fl = 32'h0;
    rd(FCP_OFS_STAT, 32'h0);
    cmd(FCP_C_ERASE_BP, 32'h0e1, FCP_MINFO_RST);
    cmd(FCP_C_SET_KEY, 32'h0e1, FCP_MINFO_RST);
    cmd(FCP_C_KEY_LOCK, 32'h0e1, 32'h1fffffff);
    // Boot page under key lock runs only through the boot permit
    cmd(FCP_C_WRITE, 32'h0e1, 32'h1fffffff);
    wr(FCP_OFS_CLR, 32'h1);
    fl = 32'h0;
    cmd(FCP_C_UNLOCK, 32'h021, FCP_MINFO_RST);
    wr(FCP_OFS_BND, b);
    cmd(FCP_C_SET_BND, 32'h021, {4'h0, b[27:0]});
    cmd(FCP_C_PERM_LOCK, 32'h021, {4'h2, b[27:0]});
    cmd(8'h05, 32'h121, {4'h2, b[27:0]});
    wr(FCP_OFS_ENV, e);
    cmd(FCP_C_ENV_LOAD, 32'h021, e);
    repeat (5) @(posedge aclk);
    if (expq.size() != 0 || bq.size() != 0)
      n_fail++;
    results();
  end
endmodule : tb_top
